// ===== tscp_pkg.sv
// Purpose: Shared constants and types for the test set control port
// Assumes: APB register map, 25 MHz core clock
// Notes:   Offsets are byte addresses of aligned 32-bit words
`default_nettype none
package tscp_pkg;

	// Register byte offsets
	localparam int          APB_AW      = 8;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_CMD    = 8'h04;
	localparam logic [7:0]  ADDR_STAT   = 8'h08;
	localparam logic [7:0]  ADDR_LOOP   = 8'h0C;
	localparam logic [7:0]  ADDR_SWEEP  = 8'h10;

	// Control register reset and writable mask
	localparam logic [31:0] CTRL_RESET  = 32'h003F0100;
	localparam logic [31:0] CTRL_MASK   = 32'h003F7F77;
	localparam int          CTRL_DIR_BIT = 8;

	// Sequence slot range, parallel input bit range and width
	localparam logic [2:0]  SLOT_FIRST  = 3'h1;
	localparam logic [2:0]  SLOT_LAST   = 3'h6;
	localparam logic [2:0]  PAR_BIT_MAX = 3'h4;
	localparam int          PAR_W       = 5;

	// Decision command opcodes
	localparam logic [3:0]  OP_DO       = 4'h1;
	localparam logic [3:0]  OP_IF_PASS  = 4'h2;
	localparam logic [3:0]  OP_IF_FAIL  = 4'h3;
	localparam logic [3:0]  OP_IF_LZERO = 4'h4;
	localparam logic [3:0]  OP_IF_LNZ   = 4'h5;
	localparam logic [3:0]  OP_IF_BITH  = 4'h6;
	localparam logic [3:0]  OP_IF_BITL  = 4'h7;
	localparam logic [3:0]  OP_LOOP_LD  = 4'h8;
	localparam logic [3:0]  OP_LOOP_INC = 4'h9;
	localparam logic [3:0]  OP_LOOP_DEC = 4'hA;

	// Sequencing output modes
	localparam logic [1:0]  TTL_HIGH    = 2'h0;
	localparam logic [1:0]  TTL_LOW     = 2'h1;
	localparam logic [1:0]  TTL_PHIGH   = 2'h2;
	localparam logic [1:0]  TTL_PLOW    = 2'h3;

	// End-of-sweep pulse length
	localparam int          CLK_NS      = 40;
	localparam int          PULSE_NS    = 1000;
	localparam int          PULSE_CYC   = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          PCNT_W      = $clog2(PULSE_CYC + 1);
	localparam logic [PCNT_W-1:0] PULSE_LOAD = PCNT_W'(PULSE_CYC);

	typedef struct packed {
		logic [9:0] unused_hi;
		logic [5:0] resident;
		logic       rsv15;
		logic [2:0] parallel_input_bit_select;
		logic       gpio_en;
		logic [1:0] ttl_mode;
		logic       fwd_dir;
		logic       rsv7;
		logic [2:0] reverse_port_code;
		logic       rsv3;
		logic [2:0] forward_port_code;
	} tscp_ctrl_s;

	typedef struct packed {
		logic [15:0] operand;
		logic [8:0]  rsv;
		logic [2:0]  dest;
		logic [3:0]  op;
	} tscp_cmd_s;

	typedef struct packed {
		logic [21:0] zero;
		logic        stb_valid;
		logic        sweep_pend;
		logic        holdoff;
		logic        limit_pass;
		logic        err;
		logic        taken;
		logic        rsv3;
		logic [2:0]  slot;
	} tscp_stat_s;

	typedef enum logic [1:0] {STB_VALID, STB_DROP, STB_LOAD} tscp_stb_e;

endpackage
`default_nettype wire

// ===== tscp_top.sv
// Purpose: Test set control port and sequence decision logic
// Assumes: APB slave, zero wait states, one clock domain
// Notes:   Pins are synchronised, limit and sweep events are core logic
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Lowest code line is high for odd codes 1, 3, 5, 7.
// - Middle code line is high for codes 2, 3, 6, 7.
// - Top code line is high for codes 4, 5, 6, 7.
// - Active-low strobe is low while code lines carry a valid code.
// - Direction line high in forward, low in reverse, follows active port.
// - No new sweep starts while hold-off input is asserted.
// - Port mirrors the sequencing output and the limit-test result.
// - Sequencing output: steady high, steady low, high or low end-sweep pulse.
// - Every jump resolves to slot 1 to 6, regardless of title.
// - Jumps are one-way, to own or other resident slot only.
// - Jump to own slot restarts it from its first command.
// - Pass and fail branches jump only when last limit result matches.
// - One loop register, loadable, incremented or decremented by one.
// - Branches on loop register equal zero or not equal zero.
// - Parallel input branches only while the port is in general mode.
// - Separate forward and reverse codes; active direction's code is output.
// - Select parallel input bit 0 to 4; branch on high or low.
module tscp_top
	import tscp_pkg::*;
#(
	parameter int LOOP_W = 16
) (
	input  wire logic              CORE_CLK,      // Core clock
	input  wire logic              RST_N,         // Sync reset, low
	input  wire logic              PSEL,          // APB select
	input  wire logic              PENABLE,       // APB enable
	input  wire logic              PWRITE,        // APB write
	input  wire logic [APB_AW-1:0] PADDR,         // APB address
	input  wire logic [31:0]       PWDATA,        // APB write data
	output logic      [31:0]       PRDATA,        // APB read data
	output logic                   PREADY,        // APB ready
	output logic                   PSLVERR,       // APB error
	input  wire logic              HOLDOFF_PIN,   // Sweep hold-off pin
	input  wire logic [PAR_W-1:0]  PAR_IN,        // Parallel input pins
	input  wire logic              LIMIT_VALID,   // Limit result strobe
	input  wire logic              LIMIT_PASS,    // Limit result level
	input  wire logic              SWEEP_END,     // End of sweep pulse
	output logic                   SWEEP_START,   // Start sweep pulse
	output logic      [2:0]        TS_CODE,       // Port code lines
	output logic                   TS_VALID_N,    // Code valid strobe
	output logic                   TS_DIR_FWD,    // Forward direction
	output logic                   TS_SEQ_OUT,    // Port sequencing copy
	output logic                   TS_LIMIT_OUT,  // Port limit copy
	output logic                   SEQ_TTL_OUT,   // Sequencing output
	output logic                   LIMIT_BNC_OUT, // Limit output
	output logic                   SEQ_JUMP,      // Jump or restart pulse
	output logic      [2:0]        SEQ_SLOT       // Running slot
);
	// Refuse loop widths outside the operand field
	if (LOOP_W < 1 || LOOP_W > 16) begin : g_chk
		$error("LOOP_W must be 1 to 16");
	end
	localparam logic [LOOP_W-1:0] LOOP_ONE  = LOOP_W'(1);
	localparam logic [LOOP_W-1:0] LOOP_ZERO = '0;
	// Exact byte address match
	function automatic logic addr_hit(input logic [APB_AW-1:0] a, input logic [7:0] off);
		return a == off;
	endfunction
	// Opcode is a branch command
	function automatic logic is_branch(input logic [3:0] op);
		return op inside {OP_DO, OP_IF_PASS, OP_IF_FAIL, OP_IF_LZERO,
			OP_IF_LNZ, OP_IF_BITH, OP_IF_BITL};
	endfunction
	// Opcode reads a parallel input
	function automatic logic is_par(input logic [3:0] op);
		return op == OP_IF_BITH || op == OP_IF_BITL;
	endfunction
	tscp_ctrl_s        ctrl_reg;
	logic [LOOP_W-1:0] loop_reg, loop_next;
	logic [2:0]        slot_reg;
	logic              jump_reg, taken_reg, err_reg, err_next;
	logic              limit_reg, pend_reg, busy_reg;
	logic              hold_s1, hold_s2;
	logic [PAR_W-1:0]  par_s1, par_s2;
	logic [2:0]        code_reg;
	logic              valid_n_reg, ttl_reg;
	logic [PCNT_W-1:0] pcnt_reg;
	logic [31:0]       rdata_reg;
	tscp_stb_e         stb_reg, stb_next;
	// APB decode
	wire        setup    = PSEL & ~PENABLE;
	wire        acc      = PSEL & PENABLE;
	wire        hit_ctrl = addr_hit(PADDR, ADDR_CTRL);
	wire        hit_cmd  = addr_hit(PADDR, ADDR_CMD);
	wire        hit_stat = addr_hit(PADDR, ADDR_STAT);
	wire        hit_loop = addr_hit(PADDR, ADDR_LOOP);
	wire        hit_swp  = addr_hit(PADDR, ADDR_SWEEP);
	wire        mapped   = hit_ctrl | hit_cmd | hit_stat | hit_loop | hit_swp;
	wire        wr       = acc & PWRITE;
	wire        wr_ctrl  = wr & hit_ctrl;
	wire        wr_cmd   = wr & hit_cmd;
	wire        wr_stat  = wr & hit_stat;
	wire        wr_swp   = wr & hit_swp;
	tscp_cmd_s  cmd;
	tscp_stat_s stat_w;
	tscp_stat_s stat_wr;
	assign cmd     = tscp_cmd_s'(PWDATA);
	assign stat_wr = tscp_stat_s'(PWDATA);
	// Bus answer
	assign PREADY  = 1'b1;
	assign PSLVERR = acc & ~mapped;
	assign PRDATA  = rdata_reg;
	// Status view
	assign stat_w = '{zero: '0, stb_valid: ~valid_n_reg, sweep_pend: pend_reg,
		holdoff: hold_s2, limit_pass: limit_reg, err: err_reg,
		taken: taken_reg, rsv3: 1'b0, slot: slot_reg};
	// Read data mux
	wire [31:0] rd_mux = hit_ctrl ? (ctrl_reg & CTRL_MASK) :
		hit_stat ? stat_w :
		hit_loop ? 32'(loop_reg) :
		hit_swp  ? {31'h0, pend_reg} : 32'h0;
	// Read data captured in setup phase
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N)
			rdata_reg <= 32'h0;
		else if (setup)
			rdata_reg <= rd_mux;
	end
	// Control register
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N)
			ctrl_reg <= tscp_ctrl_s'(CTRL_RESET);
		else if (wr_ctrl)
			ctrl_reg <= tscp_ctrl_s'(PWDATA & CTRL_MASK);
	end
	// Pin synchronisers
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			hold_s1 <= 1'b0;
			hold_s2 <= 1'b0;
			par_s1  <= '0;
			par_s2  <= '0;
		end else begin
			hold_s1 <= HOLDOFF_PIN;
			hold_s2 <= hold_s1;
			par_s1  <= PAR_IN;
			par_s2  <= par_s1;
		end
	end
	wire [2:0] psel_b  = ctrl_reg.parallel_input_bit_select;
	wire       bit_ok  = ctrl_reg.gpio_en & (psel_b <= PAR_BIT_MAX);
	wire       par_bit = (psel_b <= PAR_BIT_MAX) ? par_s2[psel_b] : 1'b0;
	wire       dest_in = (cmd.dest >= SLOT_FIRST) & (cmd.dest <= SLOT_LAST);
	wire [2:0] dest_ix = cmd.dest - SLOT_FIRST;
	wire       dest_ok = dest_in & ctrl_reg.resident[dest_ix];
	wire cond = (cmd.op == OP_DO) |
		((cmd.op == OP_IF_PASS) & limit_reg) |
		((cmd.op == OP_IF_FAIL) & ~limit_reg) |
		((cmd.op == OP_IF_LZERO) & (loop_reg == LOOP_ZERO)) |
		((cmd.op == OP_IF_LNZ) & (loop_reg != LOOP_ZERO)) |
		((cmd.op == OP_IF_BITH) & bit_ok & par_bit) |
		((cmd.op == OP_IF_BITL) & bit_ok & ~par_bit);
	// one-way jump only to resident slot
	wire jump_go = wr_cmd & is_branch(cmd.op) & cond & dest_ok;
	wire bad_op  = ~is_branch(cmd.op) & (cmd.op > OP_LOOP_DEC);
	wire err_set = wr_cmd & ((is_branch(cmd.op) & ~dest_ok) |
		(is_par(cmd.op) & ~bit_ok) | bad_op);
	// Error flag, set wins over clear
	assign err_next = err_set | (err_reg & ~(wr_stat & stat_wr.err));
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			slot_reg  <= SLOT_FIRST;
			jump_reg  <= 1'b0;
			taken_reg <= 1'b0;
			err_reg   <= 1'b0;
		end else begin
			jump_reg <= jump_go;
			err_reg  <= err_next;
			if (jump_go)
				slot_reg <= cmd.dest;
			if (wr_cmd)
				taken_reg <= jump_go;
		end
	end
	assign SEQ_JUMP = jump_reg;
	assign SEQ_SLOT = slot_reg;
	assign loop_next = !wr_cmd ? loop_reg :
		(cmd.op == OP_LOOP_LD)  ? cmd.operand[LOOP_W-1:0] :
		(cmd.op == OP_LOOP_INC) ? loop_reg + LOOP_ONE :
		(cmd.op == OP_LOOP_DEC) ? loop_reg - LOOP_ONE : loop_reg;

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N)
			loop_reg <= '0;
		else
			loop_reg <= loop_next;
	end
	// Limit result latch
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N)
			limit_reg <= 1'b0;
		else if (LIMIT_VALID)
			limit_reg <= LIMIT_PASS;
	end
	assign LIMIT_BNC_OUT = limit_reg;
	assign TS_LIMIT_OUT  = limit_reg;
	// sweep start held off by the test set
	wire start_go = pend_reg & ~busy_reg & ~hold_s2;

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			pend_reg    <= 1'b0;
			busy_reg    <= 1'b0;
			SWEEP_START <= 1'b0;
		end else begin
			pend_reg    <= (wr_swp & PWDATA[0]) | (pend_reg & ~start_go);
			busy_reg    <= start_go | (busy_reg & ~SWEEP_END);
			SWEEP_START <= start_go;
		end
	end
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N)
			pcnt_reg <= '0;
		else if (SWEEP_END)
			pcnt_reg <= PULSE_LOAD;
		else if (pcnt_reg != '0)
			pcnt_reg <= pcnt_reg - PCNT_W'(1);
	end
	wire p_act = pcnt_reg != '0;
	wire ttl_next = (ctrl_reg.ttl_mode == TTL_HIGH)  ? 1'b1 :
		(ctrl_reg.ttl_mode == TTL_LOW)   ? 1'b0 :
		(ctrl_reg.ttl_mode == TTL_PHIGH) ? p_act : ~p_act;

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N)
			ttl_reg <= 1'b1;
		else
			ttl_reg <= ttl_next;
	end
	assign SEQ_TTL_OUT = ttl_reg;
	assign TS_SEQ_OUT  = ttl_reg;
	assign TS_DIR_FWD = ctrl_reg.fwd_dir;
	wire [2:0] sel_code  = ctrl_reg.fwd_dir ? ctrl_reg.forward_port_code
		: ctrl_reg.reverse_port_code;
	wire       code_diff = sel_code != code_reg;
	always_comb begin
		stb_next = stb_reg;
		unique case (stb_reg)
			STB_VALID: stb_next = code_diff ? STB_DROP : STB_VALID;
			STB_DROP:  stb_next = STB_LOAD;
			STB_LOAD:  stb_next = STB_VALID;
		endcase
	end
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			stb_reg     <= STB_VALID;
			code_reg    <= 3'h0;
			valid_n_reg <= 1'b0;
		end else begin
			stb_reg     <= stb_next;
			valid_n_reg <= stb_next != STB_VALID;
			if (stb_reg == STB_DROP)
				code_reg <= sel_code;
		end
	end
	assign TS_CODE    = code_reg;
	assign TS_VALID_N = valid_n_reg;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	sequence s_drop; TS_VALID_N; endsequence
	sequence s_load; TS_VALID_N && TS_CODE == $past(sel_code); endsequence
	property p_bit0;
		!TS_VALID_N && !code_diff |-> TS_CODE[0] == (sel_code inside {3'h1, 3'h3, 3'h5, 3'h7});
	endproperty
	a_bit0: assert property (p_bit0) else $error("code bit 0 wrong");
	property p_bit1;
		!TS_VALID_N && !code_diff |-> TS_CODE[1] == (sel_code inside {3'h2, 3'h3, 3'h6, 3'h7});
	endproperty
	a_bit1: assert property (p_bit1) else $error("code bit 1 wrong");
	property p_bit2;
		!TS_VALID_N && !code_diff |-> TS_CODE[2] == (sel_code inside {3'h4, 3'h5, 3'h6, 3'h7});
	endproperty
	a_bit2: assert property (p_bit2) else $error("code bit 2 wrong");
	property p_strobe;
		$changed(TS_CODE) |-> TS_VALID_N && $past(TS_VALID_N);
	endproperty
	a_strobe: assert property (p_strobe) else $error("code moved under strobe");
	property p_seq;
		!TS_VALID_N && code_diff |=> s_drop ##1 s_load ##1 !TS_VALID_N;
	endproperty
	a_seq: assert property (p_seq) else $error("strobe sequence broken");
	property p_dir; wr_ctrl |=> TS_DIR_FWD == $past(PWDATA[CTRL_DIR_BIT]); endproperty
	a_dir: assert property (p_dir) else $error("direction not tracked");
	property p_hold; hold_s2 |=> !SWEEP_START; endproperty
	a_hold: assert property (p_hold) else $error("sweep started in hold-off");
	property p_lim;
		LIMIT_VALID |=> TS_LIMIT_OUT == $past(LIMIT_PASS) && LIMIT_BNC_OUT == TS_LIMIT_OUT;
	endproperty
	a_lim: assert property (p_lim) else $error("limit copy wrong");
	property p_phigh;
		SWEEP_END && ctrl_reg.ttl_mode == TTL_PHIGH && !wr_ctrl |=> ##1 SEQ_TTL_OUT && TS_SEQ_OUT;
	endproperty
	a_phigh: assert property (p_phigh) else $error("no end sweep pulse");
	property p_jump;
		jump_go |=> SEQ_JUMP && SEQ_SLOT == $past(cmd.dest) && SEQ_SLOT inside {[1:6]};
	endproperty
	a_jump: assert property (p_jump) else $error("jump slot wrong");
	property p_absent;
		wr_cmd && is_branch(cmd.op) && !dest_ok |=> !SEQ_JUMP && $stable(SEQ_SLOT) && err_reg;
	endproperty
	a_absent: assert property (p_absent) else $error("jump to absent slot");
	property p_pass; wr_cmd && cmd.op == OP_IF_PASS && !limit_reg |=> !SEQ_JUMP; endproperty
	a_pass: assert property (p_pass) else $error("pass branch on fail");
	property p_dec; wr_cmd && cmd.op == OP_LOOP_DEC |=> loop_reg == $past(loop_reg) - LOOP_ONE; endproperty
	a_dec: assert property (p_dec) else $error("loop decrement wrong");
	property p_lz; wr_cmd && cmd.op == OP_IF_LZERO && loop_reg != LOOP_ZERO |=> !SEQ_JUMP; endproperty
	a_lz: assert property (p_lz) else $error("zero branch taken");
	property p_gpio; wr_cmd && is_par(cmd.op) && !ctrl_reg.gpio_en |=> !SEQ_JUMP; endproperty
	a_gpio: assert property (p_gpio) else $error("parallel branch outside mode");

endmodule // tscp_top

`default_nettype wire

// ===== tscp_ts_model.sv
// Purpose: Far-side test set seen through the control port
// Assumes: Same clock as the port, sync reset active low
// Notes:   Latches the code on the low strobe, holds off sweeps
`timescale 1ns/10ps
`default_nettype none
module tscp_ts_model (
	input  wire logic       clk,       // Core clock
	input  wire logic       rst_n,     // Sync reset, low
	input  wire logic [2:0] code,      // Port code lines
	input  wire logic       valid_n,   // Code valid strobe
	input  wire logic       sweep_st,  // Device sweep start
	input  wire logic [7:0] hold_len,  // Own sweep length
	output logic            holdoff,   // Sweep hold-off line
	output logic      [2:0] latched,   // Latched code
	output logic     [15:0] bad_cnt    // Code moved under strobe
);
	logic [7:0] hold_cnt;
	logic       prev_v;
	logic [2:0] prev_c;

	// hold-off kept until own sweep ends
	assign holdoff = hold_cnt != 8'h00;

	// latch on low strobe, start trigger left open
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_cnt <= 8'h00;
			latched  <= 3'h0;
			bad_cnt  <= 16'h0000;
			prev_v   <= 1'b1;
			prev_c   <= 3'h0;
		end else begin
			if (sweep_st)
				hold_cnt <= hold_len;
			else if (hold_cnt != 8'h00)
				hold_cnt <= hold_cnt - 8'h01;
			if (!valid_n)
				latched <= code;
			if (!valid_n && !prev_v && code !== prev_c)
				bad_cnt <= bad_cnt + 16'h0001;
			prev_v <= valid_n;
			prev_c <= code;
		end
	end
endmodule // tscp_ts_model
`default_nettype wire

// ===== tb_test_set_control_port.sv
// Purpose: Self-checking bench for the test set control port
// Assumes: Zero-wait APB, inputs driven at the rising edge
// Notes:   Partner model holds off sweeps and latches codes
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_test_set_control_port;
	import tscp_pkg::*;
	logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0, hold_len = 0;
	logic [31:0] pwdata = 0, prdata, rdata;
	logic [4:0]  par_in = 0;
	logic        lim_v = 0, lim_p = 0, sw_end = 0, pready, pslverr, err_seen;
	logic        sw_st, vld_n, dir_fwd, seq_o, lim_o, ttl_o, bnc_o, jump, holdoff;
	logic [2:0]  code, slot, latched;
	logic [15:0] bad_cnt;
	tscp_stat_s  st;
	int          miscompares = 0, num_checks = 0, n;

	// Clock, 40 ns period
	initial begin
		forever #20 clk = ~clk;
	end

	tscp_top DUT (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.HOLDOFF_PIN(holdoff), .PAR_IN(par_in), .LIMIT_VALID(lim_v), .LIMIT_PASS(lim_p),
		.SWEEP_END(sw_end), .SWEEP_START(sw_st), .TS_CODE(code), .TS_VALID_N(vld_n),
		.TS_DIR_FWD(dir_fwd), .TS_SEQ_OUT(seq_o), .TS_LIMIT_OUT(lim_o), .SEQ_TTL_OUT(ttl_o),
		.LIMIT_BNC_OUT(bnc_o), .SEQ_JUMP(jump), .SEQ_SLOT(slot));

	tscp_ts_model PART (.clk(clk), .rst_n(rst_n), .code(code), .valid_n(vld_n), .sweep_st(sw_st),
		.hold_len(hold_len), .holdoff(holdoff), .latched(latched), .bad_cnt(bad_cnt));

	// Verdict and end of run
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// One APB transfer, held until ready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			miscompares++;
			final_report();
		end
		rdata = prdata;
		err_seen = pslverr;
		psel <= 0; penable <= 0;
	endtask

	// Control word from its fields
	function automatic logic [31:0] mk(input logic [2:0] f, r, input logic d, input logic [1:0] m,
		input logic g, input logic [2:0] s, input logic [5:0] res);
		mk = tscp_ctrl_s'({10'h000, res, 1'b0, s, g, m, d, 1'b0, r, 1'b0, f});
	endfunction

	// Command, then jump and slot judged
	task cmd(input logic [3:0] op, input logic [2:0] dst, input logic [15:0] v, input logic ej,
		input logic [2:0] es);
		logic j;
		apb(1, ADDR_CMD, {v, 9'h000, dst, op});
		j = 0;
		repeat (3) begin
			@(negedge clk);
			if (jump === 1'b1) j = 1;
		end
		`CHK(j, ej)
		`CHK(slot, es)
	endtask

	// Port code change seen at the lines
	task code_chk(input logic [2:0] f, r, input logic d, input logic [2:0] e);
		apb(1, ADDR_CTRL, mk(f, r, d, TTL_HIGH, 0, 0, 6'h3F));
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(vld_n === 1'b0 && code === e) && n < 8);
		`CHK(vld_n, 1'b0)
		`CHK(code[0], (e inside {3'h1, 3'h3, 3'h5, 3'h7}))
		`CHK(code[1], (e inside {3'h2, 3'h3, 3'h6, 3'h7}))
		`CHK(code[2], (e inside {3'h4, 3'h5, 3'h6, 3'h7}))
		`CHK(dir_fwd, d)
		@(negedge clk);
		`CHK(latched, e)
		`CHK(bad_cnt, 16'h0000)
	endtask

	// Limit result pulse and its copies
	task lim(input logic p);
		@(posedge clk);
		lim_v <= 1; lim_p <= p;
		@(posedge clk);
		lim_v <= 0;
		@(negedge clk);
		`CHK(lim_o, p)
		`CHK(bnc_o, p)
	endtask

	// End of sweep pulse
	task pulse_end;
		@(posedge clk);
		sw_end <= 1;
		@(posedge clk);
		sw_end <= 0;
	endtask

	// Sequencing output mode over one sweep end
	task ttl(input logic [1:0] m, input logic idle, input int e);
		int c;
		apb(1, ADDR_CTRL, mk(3'h6, 3'h5, 1, m, 0, 0, 6'h3F));
		repeat (3) @(negedge clk);
		`CHK(ttl_o, idle)
		pulse_end();
		c = 0;
		repeat (40) begin
			@(negedge clk);
			if (ttl_o !== idle) c++;
			`CHK(seq_o, ttl_o)
		end
		`CHK(c, e)
	endtask

	// Bounded wait for a sweep start
	task wait_start;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sw_st !== 1'b1 && n < 40);
		`CHK(sw_st, 1'b1)
	endtask

	// Hang guard
	initial begin
		repeat (50000) @(posedge clk);
		miscompares++;
		final_report();
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		`CHK(dir_fwd, 1'b1)
		`CHK(slot, SLOT_FIRST)
		rst_n <= 1;
		apb(0, ADDR_CTRL, 0);
		`CHK(rdata, CTRL_RESET)
		apb(0, 8'h14, 0);
		`CHK(err_seen, 1'b1)
		for (int c = 0; c < 8; c++)
			code_chk(c[2:0], 3'h0, 1, c[2:0]);
		code_chk(3'h7, 3'h5, 0, 3'h5);
		code_chk(3'h6, 3'h5, 1, 3'h6);
		apb(1, ADDR_CTRL, mk(3'h6, 3'h5, 1, TTL_HIGH, 1, PAR_BIT_MAX, 6'h2F));
		cmd(OP_DO, 3'h3, 0, 1, 3'h3);
		cmd(OP_DO, 3'h3, 0, 1, 3'h3);
		cmd(OP_DO, 3'h5, 0, 0, 3'h3);
		apb(0, ADDR_STAT, 0);
		st = rdata;
		`CHK(st.err, 1'b1)
		apb(1, ADDR_STAT, 32'h00000020);
		cmd(OP_DO, 3'h0, 0, 0, 3'h3);
		cmd(OP_DO, 3'h7, 0, 0, 3'h3);
		lim(1);
		cmd(OP_IF_PASS, 3'h2, 0, 1, 3'h2);
		cmd(OP_IF_FAIL, 3'h4, 0, 0, 3'h2);
		lim(0);
		cmd(OP_IF_PASS, 3'h4, 0, 0, 3'h2);
		cmd(OP_IF_FAIL, 3'h6, 0, 1, 3'h6);
		cmd(OP_LOOP_LD, 3'h1, 16'h0002, 0, 3'h6);
		cmd(OP_IF_LZERO, 3'h1, 0, 0, 3'h6);
		cmd(OP_LOOP_DEC, 3'h1, 0, 0, 3'h6);
		cmd(OP_IF_LNZ, 3'h1, 0, 1, 3'h1);
		cmd(OP_LOOP_DEC, 3'h1, 0, 0, 3'h1);
		cmd(OP_IF_LNZ, 3'h2, 0, 0, 3'h1);
		cmd(OP_IF_LZERO, 3'h2, 0, 1, 3'h2);
		cmd(OP_LOOP_DEC, 3'h1, 0, 0, 3'h2);
		apb(0, ADDR_LOOP, 0);
		`CHK(rdata[15:0], 16'hFFFF)
		cmd(OP_LOOP_INC, 3'h1, 0, 0, 3'h2);
		cmd(OP_IF_LZERO, 3'h3, 0, 1, 3'h3);
		@(posedge clk);
		par_in <= 5'h10;
		repeat (4) @(posedge clk);
		cmd(OP_IF_BITH, 3'h4, 0, 1, 3'h4);
		cmd(OP_IF_BITL, 3'h1, 0, 0, 3'h4);
		@(posedge clk);
		par_in <= 5'h0F;
		repeat (4) @(posedge clk);
		cmd(OP_IF_BITL, 3'h1, 0, 1, 3'h1);
		cmd(OP_IF_BITH, 3'h2, 0, 0, 3'h1);
		apb(1, ADDR_CTRL, mk(3'h6, 3'h5, 1, TTL_HIGH, 0, PAR_BIT_MAX, 6'h3F));
		cmd(OP_IF_BITL, 3'h2, 0, 0, 3'h1);
		ttl(TTL_HIGH, 1, 0);
		ttl(TTL_LOW, 0, 0);
		ttl(TTL_PHIGH, 0, PULSE_CYC);
		ttl(TTL_PLOW, 1, PULSE_CYC);
		@(posedge clk);
		hold_len <= 8'd14;
		apb(1, ADDR_SWEEP, 32'h00000001);
		wait_start();
		repeat (4) @(negedge clk);
		pulse_end();
		apb(1, ADDR_SWEEP, 32'h00000001);
		wait_start();
		`CHK(holdoff, 1'b0)
		pulse_end();
		final_report();
	end
endmodule // tb_test_set_control_port
`default_nettype wire
